// file: logic/vpc_pkg.sv
// Constants, register map, format presets and types of the video port control.
// Assumes one aclk domain; video clock and pins arrive unsynchronised.
// Summary of operation
// - Suspend input high means processor halted
// - Receive channel finishes current frame, then stalls
// - Receive side has soft stop only
// - Config written under suspend waits post-suspend vsync
// - Transmit keeps outputting to frame end
// - Stalled transmit raises no frame interrupts
// - Stalled transmit repeats same frame, ignores config
// - Transmit resumes normally after suspend drops
// - Clearing enable stops channel at once
// - Control register writes act immediately
// - Transmit control holds a pixel output enable
// - Late pixel enable flags underflow until vsync
// - BT.656 blank 268/280, active 1440 bytes
// - BT.656 lines 525/625 and boundary lines
// - 1080i blank 272/376, active 1920 bytes
// - 1080i lines 1125/1250 and boundary lines
// - 1080p60 only on high-rate device grades
// - 27 MHz input clock also times output
// - Channels 0-1 receive, 2-3 transmit, shared clock
// - Frame interrupt at EAV on L1, L7 optional
// - Other config captured at vsync falling edge
package vpc_pkg;
   localparam int NUM_CH = 4;
   localparam int NUM_RX = 2;
   localparam int NUM_CFG_WORDS = 5;
   localparam int LINE_W = 12;
   localparam int BYTE_W = 13;

   // Offsets: per-channel block, then one global word
   localparam int CH_SEL_LSB = 5;
   localparam logic [4:0] OFF_CTRL = 5'h00;
   localparam logic [4:0] OFF_HSIZE = 5'h04;
   localparam logic [4:0] OFF_VSIZE = 5'h08;
   localparam logic [4:0] OFF_VCFG_A = 5'h0c;
   localparam logic [4:0] OFF_VCFG_B = 5'h10;
   localparam logic [4:0] OFF_VCFG_C = 5'h14;
   localparam logic [4:0] OFF_STATUS = 5'h18;
   localparam logic [7:0] OFF_GLOBAL = 8'h80;

   // Field positions
   localparam int HI_FIELD_LSB = 16;
   localparam int CTRL_HIRATE_BIT = 3;
   localparam int STAT_LINE_LSB = 16;

   // Sync code bytes and bus answers
   localparam logic [7:0] CODE_FF = 8'hff;
   localparam logic [7:0] CODE_00 = 8'h00;
   localparam int XY_H_BIT = 4;
   localparam logic [7:0] BLANK_LEVEL = 8'h10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic hi_rate;
      logic field_irq;
      logic pix_en;
      logic enable;
   } vpc_ctrl_t;

   typedef struct packed {
      logic [BYTE_W-1:0] blank_len;
      logic [BYTE_W-1:0] active_len;
      logic [LINE_W-1:0] lines;
      logic [LINE_W-1:0] l1;
      logic [LINE_W-1:0] l3;
      logic [LINE_W-1:0] l5;
      logic [LINE_W-1:0] l7;
      logic [LINE_W-1:0] l9;
      logic [LINE_W-1:0] l11;
   } vpc_cfg_t;

   localparam vpc_ctrl_t CTRL_RESET = '0;

   // Format presets; NTSC is the reset value
   localparam vpc_cfg_t FMT_NTSC = '{13'h10c, 13'h5a0, 12'h20d, 12'h004, 12'h014,
      12'h108, 12'h10a, 12'h11b, 12'h001};
   localparam vpc_cfg_t FMT_PAL = '{13'h118, 13'h5a0, 12'h271, 12'h001, 12'h017,
      12'h137, 12'h139, 12'h150, 12'h270};
   localparam vpc_cfg_t FMT_1080I60 = '{13'h110, 13'h780, 12'h465, 12'h001, 12'h029,
      12'h22e, 12'h234, 12'h25b, 12'h461};
   localparam vpc_cfg_t FMT_1080I50 = '{13'h178, 13'h780, 12'h4e2, 12'h001, 12'h02d,
      12'h26d, 12'h272, 12'h29e, 12'h4de};
   localparam vpc_cfg_t CFG_RESET = FMT_NTSC;

   // Packs one configuration word
   function automatic logic [31:0] cfg_word(input vpc_cfg_t c, input int idx);
      logic [31:0] w;
      w = '0;
      case (idx)
         0: w = {3'h0, c.active_len, 3'h0, c.blank_len};
         1: w = {20'h0, c.lines};
         2: w = {4'h0, c.l3, 4'h0, c.l1};
         3: w = {4'h0, c.l7, 4'h0, c.l5};
         default: w = {4'h0, c.l11, 4'h0, c.l9};
      endcase
      return w;
   endfunction
endpackage

// file: logic/vpc_top.sv
// Four-channel video port control: two receive, two transmit channels.
// Assumes an AXI4-Lite master on aclk; video clock and pins are asynchronous.
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
module vpc_top import vpc_pkg::*; #(
   parameter bit HIGH_RATE_GRADE = 1'b0
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Video link and debug suspend
   input wire logic vid_clk,
   input wire logic [1:0] dbg_suspend,
   input wire logic [7:0] rx_pin [NUM_RX],
   // Captured data towards memory
   output logic [7:0] rx_data [NUM_RX],
   output logic [NUM_RX-1:0] rx_valid,
   // Transmit fetch side and pixel pins
   input wire logic [7:0] tx_fetch_data [NUM_CH-NUM_RX],
   output logic [NUM_CH-NUM_RX-1:0] tx_fetch_start,
   output logic [NUM_CH-NUM_RX-1:0] tx_fetch_repeat,
   output logic [7:0] tx_pin [NUM_CH-NUM_RX],
   output logic [NUM_CH-NUM_RX-1:0] tx_pix_active,
   output logic [NUM_CH-NUM_RX-1:0] tx_underflow,
   // Frame events
   output logic [NUM_CH-1:0] frame_irq
);

   // Line range test; a range may wrap past the frame end
   function automatic logic in_range(input logic [LINE_W-1:0] l, input logic [LINE_W-1:0] a,
                                     input logic [LINE_W-1:0] b);
      return (a <= b) ? (l >= a && l <= b) : (l >= a || l <= b);
   endfunction

   function automatic logic v_active(input logic [LINE_W-1:0] l, input vpc_cfg_t c);
      return in_range(l, c.l3, c.l5) || in_range(l, c.l9, c.l11);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic mapped(input logic [7:0] a, input logic wr);
      logic ok;
      ok = (a == OFF_GLOBAL);
      if (!a[7]) begin
         ok = (a[4:0] <= OFF_STATUS) && (a[1:0] == 2'h0) && !(wr && a[4:0] == OFF_STATUS);
      end
      return ok;
   endfunction

   function automatic vpc_cfg_t word_cfg(input logic [31:0] w [NUM_CFG_WORDS]);
      vpc_cfg_t c;
      c.blank_len = w[0][BYTE_W-1:0];
      c.active_len = w[0][HI_FIELD_LSB +: BYTE_W];
      c.lines = w[1][LINE_W-1:0];
      c.l1 = w[2][LINE_W-1:0];
      c.l3 = w[2][HI_FIELD_LSB +: LINE_W];
      c.l5 = w[3][LINE_W-1:0];
      c.l7 = w[3][HI_FIELD_LSB +: LINE_W];
      c.l9 = w[4][LINE_W-1:0];
      c.l11 = w[4][HI_FIELD_LSB +: LINE_W];
      return c;
   endfunction

   // Synchronisers
   logic [2:0] vclk_sync;
   logic [1:0] susp_s1;
   logic [1:0] susp_s2;
   logic [7:0] rx_s1 [NUM_RX];
   logic [7:0] rx_s2 [NUM_RX];
   logic byte_tick;
   logic susp_sel;
   logic susp;

   // Two flops per pin; the third vclk stage feeds only the edge detector
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vclk_sync <= 3'h0;
         susp_s1 <= 2'h0;
         susp_s2 <= 2'h0;
         for (int i = 0; i < NUM_RX; i++) begin
            rx_s1[i] <= 8'h00;
            rx_s2[i] <= 8'h00;
         end
      end else begin
         vclk_sync <= {vclk_sync[1:0], vid_clk};
         susp_s1 <= dbg_suspend;
         susp_s2 <= susp_s1;
         for (int i = 0; i < NUM_RX; i++) begin
            rx_s1[i] <= rx_pin[i];
            rx_s2[i] <= rx_s1[i];
         end
      end
   end

   // One video clock serves every channel
   assign byte_tick = vclk_sync[1] && !vclk_sync[2];
   assign susp = susp_s2[susp_sel];

   // AXI4-Lite slave
   logic aw_held;
   logic w_held;
   logic [7:0] waddr;
   logic [31:0] wdat;
   logic [3:0] wstb;
   logic wr_fire;
   logic [1:0] wr_ch;
   logic [2:0] wr_idx;

   assign wr_fire = aw_held && w_held && !bvalid;
   assign wr_ch = waddr[CH_SEL_LSB +: 2];
   assign wr_idx = waddr[4:2];

   // Address and data in either order, answered once both held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         waddr <= 8'h00;
         wdat <= 32'h0;
         wstb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            awready <= 1'b0;
            aw_held <= 1'b1;
            waddr <= awaddr;
         end
         if (wvalid && wready) begin
            wready <= 1'b0;
            w_held <= 1'b1;
            wdat <= wdata;
            wstb <= wstrb;
         end
         if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= mapped(waddr, 1'b1) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // Register storage
   vpc_ctrl_t ctrl [NUM_CH];
   logic [31:0] pend [NUM_CH][NUM_CFG_WORDS];

   // Control acts at once; size words wait for the vsync
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         susp_sel <= 1'b0;
         for (int c = 0; c < NUM_CH; c++) begin
            ctrl[c] <= CTRL_RESET;
            for (int k = 0; k < NUM_CFG_WORDS; k++) begin
               pend[c][k] <= cfg_word(CFG_RESET, k);
            end
         end
      end else if (wr_fire && mapped(waddr, 1'b1)) begin
         if (waddr[7]) begin
            susp_sel <= wstb[0] ? wdat[0] : susp_sel;
         end else if (wr_idx == 3'h0) begin
            ctrl[wr_ch] <= vpc_ctrl_t'(merge({28'h0, ctrl[wr_ch]}, wdat, wstb));
            if (!HIGH_RATE_GRADE) begin
               ctrl[wr_ch].hi_rate <= 1'b0;
            end
         end else begin
            pend[wr_ch][wr_idx-3'h1] <= merge(pend[wr_ch][wr_idx-3'h1], wdat, wstb);
         end
      end
   end

   // Channel engines
   vpc_cfg_t act [NUM_CH];
   logic [LINE_W-1:0] line_cnt [NUM_CH];
   logic [BYTE_W-1:0] byte_cnt [NUM_CH];
   logic [NUM_CH-1:0] stall;
   logic [NUM_CH-1:0] started;
   logic [NUM_CH-1:0] field2;
   logic [NUM_CH-1:0] vact;
   logic [NUM_CH-1:0] uflow;

   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      localparam bit IS_TX = (c >= NUM_RX);
      logic eav;
      logic h_act;
      logic frame_start;
      logic field2_start;
      logic vsync_fall;
      logic [LINE_W-1:0] next_line;
      logic [23:0] hist;

      // End of line: decoded on receive, counted out on transmit
      if (IS_TX) begin : g_eav_tx
         assign hist = 24'h0;
         assign eav = byte_tick &&
            (byte_cnt[c] == BYTE_W'(act[c].blank_len + act[c].active_len - 13'h1));
      end else begin : g_eav_rx
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               hist <= 24'h0;
            end else if (byte_tick) begin
               hist <= {hist[15:0], rx_s2[c]};
            end
         end
         assign eav = byte_tick && hist == {CODE_FF, CODE_00, CODE_00} && rx_s2[c][XY_H_BIT];
      end

      assign next_line = (line_cnt[c] >= act[c].lines) ? LINE_W'(1) : line_cnt[c] + 12'h1;
      assign h_act = byte_cnt[c] >= act[c].blank_len &&
         byte_cnt[c] < BYTE_W'(act[c].blank_len + act[c].active_len);
      assign frame_start = eav && next_line == act[c].l1;
      assign field2_start = eav && next_line == act[c].l7;
      assign vsync_fall = eav && !v_active(line_cnt[c], act[c]) && v_active(next_line, act[c]);
      assign vact[c] = v_active(line_cnt[c], act[c]);
      assign field2[c] = in_range(line_cnt[c], act[c].l7, act[c].l1 - 12'h1);

      // Position; a cleared enable drops the channel at once
      always_ff @(posedge aclk) begin
         if (!aresetn || !ctrl[c].enable) begin
            byte_cnt[c] <= '0;
            line_cnt[c] <= LINE_W'(1);
         end else if (eav) begin
            byte_cnt[c] <= '0;
            line_cnt[c] <= next_line;
         end else if (byte_tick && byte_cnt[c] != '1) begin
            byte_cnt[c] <= byte_cnt[c] + 13'h1;
         end
      end

      // Sizes follow the vsync fall, not while the processor is halted; a disabled channel takes them at once
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            act[c] <= CFG_RESET;
         end else if (!ctrl[c].enable || (vsync_fall && !susp)) begin
            act[c] <= word_cfg(pend[c]);
         end
      end

      // Stall only at a frame boundary: soft stop only
      always_ff @(posedge aclk) begin
         if (!aresetn || !ctrl[c].enable) begin
            stall[c] <= 1'b0;
            started[c] <= 1'b0;
         end else begin
            if (frame_start && susp) begin
               stall[c] <= 1'b1;
            end else if (!susp) begin
               stall[c] <= 1'b0;
            end
            if (vsync_fall) begin
               started[c] <= 1'b1;
            end
         end
      end

      // Frame events; a stalled channel keeps quiet
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            frame_irq[c] <= 1'b0;
         end else begin
            frame_irq[c] <= ctrl[c].enable && !stall[c] && !(frame_start && susp) &&
               (frame_start || (ctrl[c].field_irq && field2_start));
         end
      end

      if (IS_TX) begin : g_tx
         localparam int T = c - NUM_RX;
         logic pix_en_q;

         // Late pixel enable: underflow until the next vsync fall
         always_ff @(posedge aclk) begin
            if (!aresetn || !ctrl[c].enable) begin
               pix_en_q <= 1'b0;
               uflow[c] <= 1'b0;
            end else begin
               pix_en_q <= ctrl[c].pix_en;
               if (started[c] && ctrl[c].pix_en && !pix_en_q) begin
                  uflow[c] <= 1'b1;
               end else if (vsync_fall) begin
                  uflow[c] <= 1'b0;
               end
            end
         end

         // Output keeps running through a stall, replaying the held frame
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               tx_fetch_start[T] <= 1'b0;
               tx_fetch_repeat[T] <= 1'b0;
               tx_pin[T] <= 8'h00;
               tx_pix_active[T] <= 1'b0;
               tx_underflow[T] <= 1'b0;
            end else begin
               tx_fetch_start[T] <= ctrl[c].enable && frame_start;
               tx_fetch_repeat[T] <= stall[c] || (frame_start && susp);
               tx_pix_active[T] <= ctrl[c].enable && ctrl[c].pix_en && vact[c] && h_act;
               tx_pin[T] <= (ctrl[c].enable && ctrl[c].pix_en && vact[c] && h_act) ?
                  tx_fetch_data[T] : BLANK_LEVEL;
               tx_underflow[T] <= uflow[c];
            end
         end
      end else begin : g_rx
         assign uflow[c] = 1'b0;

         // Capture active bytes after the first vsync, unless stalled
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               rx_valid[c] <= 1'b0;
               rx_data[c] <= 8'h00;
            end else begin
               rx_valid[c] <= ctrl[c].enable && started[c] && !stall[c] && byte_tick &&
                  vact[c] && h_act && !eav;
               rx_data[c] <= rx_s2[c];
            end
         end
      end
   end

   // Read path
   logic [31:0] rd_word;
   logic [1:0] rd_ch;

   assign rd_ch = araddr[CH_SEL_LSB +: 2];

   // Read mux; status shows live position and state
   always_comb begin
      rd_word = 32'h0;
      if (araddr[7]) begin
         rd_word = {31'h0, susp_sel};
      end else if (araddr[4:0] == OFF_CTRL) begin
         rd_word = {28'h0, ctrl[rd_ch]};
      end else if (araddr[4:0] == OFF_STATUS) begin
         rd_word = {4'h0, line_cnt[rd_ch], 11'h0, uflow[rd_ch], vact[rd_ch], field2[rd_ch],
                    started[rd_ch], stall[rd_ch]};
      end else if (araddr[4:2] <= 3'h5) begin
         rd_word = pend[rd_ch][araddr[4:2]-3'h1];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= mapped(araddr, 1'b0) ? rd_word : 32'h0;
         rresp <= mapped(araddr, 1'b0) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

endmodule

// file: test/vpc_properties.sv
// Checker for suspend, enable and pixel output behaviour.
// Assumes suspend source 0 and the 8-line bench format.
`timescale 1ns/10ps
module vpc_properties import vpc_pkg::*; (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus write side
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [31:0] wdata,
   input wire logic bvalid,
   input wire logic [1:0] bresp,
   // Video side
   input wire logic [1:0] dbg_suspend,
   input wire logic [NUM_RX-1:0] rx_valid,
   input wire logic [7:0] tx_fetch_data [NUM_CH-NUM_RX],
   input wire logic [NUM_CH-NUM_RX-1:0] tx_fetch_repeat,
   input wire logic [7:0] tx_pin [NUM_CH-NUM_RX],
   input wire logic [NUM_CH-NUM_RX-1:0] tx_pix_active,
   input wire logic [NUM_CH-NUM_RX-1:0] tx_underflow,
   input wire logic [NUM_CH-1:0] frame_irq
);
   localparam int SETTLE = 2200;
   logic [7:0] wa;
   logic [31:0] wd;
   logic ctl2_wr;
   int susp_cnt, res_cnt;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Address and data of the write under way
   always_ff @(posedge aclk) begin
      if (awvalid && awready) wa <= awaddr;
      if (wvalid && wready) wd <= wdata;
   end
   // Halt time; two frames drain any frame in flight
   always_ff @(posedge aclk) begin
      if (!aresetn || !dbg_suspend[0]) susp_cnt <= 0;
      else if (susp_cnt < SETTLE) susp_cnt <= susp_cnt + 1;
   end
   // Cycles since resume
   always_ff @(posedge aclk) begin
      if (!aresetn || frame_irq[2]) res_cnt <= 0;
      else if (res_cnt > 0 || $fell(dbg_suspend[0]) && tx_fetch_repeat[0])
         res_cnt <= res_cnt + 1;
   end
   assign ctl2_wr = bvalid && bresp == RESP_OKAY && wa == 8'h40;
   property p_irq_pulse;
      frame_irq[0] |=> !frame_irq[0] [*8];
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("frame event not isolated");
   property p_stall_quiet;
      susp_cnt >= SETTLE |-> !frame_irq[0] && !frame_irq[2] && !rx_valid[0];
   endproperty
   a_stall_quiet: assert property (p_stall_quiet) else $error("activity while halted");
   property p_repeat_no_irq;
      tx_fetch_repeat[0] |-> !frame_irq[2];
   endproperty
   a_repeat_no_irq: assert property (p_repeat_no_irq) else $error("event while stalled");
   property p_repeat_hold;
      tx_fetch_repeat[0] && dbg_suspend[0] |=> tx_fetch_repeat[0];
   endproperty
   a_repeat_hold: assert property (p_repeat_hold) else $error("repeat dropped early");
   property p_repeat_clear;
      $fell(dbg_suspend[0]) |-> ##[1:5] !tx_fetch_repeat[0];
   endproperty
   a_repeat_clear: assert property (p_repeat_clear) else $error("repeat stuck");
   property p_resume;
      res_cnt <= 1300;
   endproperty
   a_resume: assert property (p_resume) else $error("no event after resume");
   property p_disable_now;
      $rose(ctl2_wr) && !(wd[0] && wd[1]) |=> !tx_pix_active[0];
   endproperty
   a_disable_now: assert property (p_disable_now) else $error("output not stopped");
   property p_underflow_cause;
      $rose(tx_underflow[0]) |-> $past(bvalid, 2) && wa == 8'h40 && wd[1]
         ##1 tx_underflow[0] [*8];
   endproperty
   a_underflow_cause: assert property (p_underflow_cause) else $error("underflow flag wrong");
   property p_tx_pin;
      tx_pix_active[0] |-> tx_pin[0] == tx_fetch_data[0];
   endproperty
   a_tx_pin: assert property (p_tx_pin) else $error("pixel byte wrong");
   c_irq2: cover property (frame_irq[2]);
   c_stall: cover property ($rose(tx_fetch_repeat[0]));
   c_under: cover property ($rose(tx_underflow[0]));
endmodule
bind vpc_top vpc_properties u_props (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
   .wready, .wdata, .bvalid, .bresp, .dbg_suspend, .rx_valid, .tx_fetch_data, .tx_fetch_repeat,
   .tx_pin, .tx_pix_active, .tx_underflow, .frame_irq);

// file: test/vpc_video_source.sv
// Video source: free-running byte clock, each line closed by an EAV code.
// Assumes receive channels use the same blank and active lengths.
`timescale 1ns/10ps
module vpc_video_source import vpc_pkg::*; #(
   parameter int BLANK = 8,
   parameter int ACTIVE = 8
) (
   // Link pins
   output logic vid_clk,
   output logic [7:0] rx_pin [NUM_RX]
);
   int idx = 0;
   logic [7:0] b;
   // Byte clock of eight aclk periods, odd offset so its edges never meet aclk edges
   initial begin
      vid_clk = 1'b0;
      #7;
      forever #160 vid_clk = ~vid_clk;
   end
   // Bytes change on the falling edge, away from the sampling edge
   always @(negedge vid_clk) idx <= (idx == BLANK + ACTIVE - 1) ? 0 : idx + 1;
   // Blank fill, data, then FF 00 00 XY closing each line
   always_comb begin
      case (BLANK + ACTIVE - 1 - idx)
         3: b = CODE_FF;
         2, 1: b = CODE_00;
         0: b = 8'h90;
         default: b = (idx < BLANK) ? BLANK_LEVEL : 8'h40 + 8'(idx);
      endcase
   end
   assign rx_pin[0] = b;
   assign rx_pin[1] = b;
endmodule

// file: test/vpc_top_tb.sv
// Self-checking bench for the video port control.
// Assumes the source model on the receive pins, constant fetch bytes.
`timescale 1ns/10ps
module vpc_top_tb import vpc_pkg::*; ;
   typedef int vpc_fmt_t [9];
   localparam vpc_fmt_t FMT [4] = '{'{268, 1440, 525, 4, 20, 264, 266, 283, 1},
      '{280, 1440, 625, 1, 23, 311, 313, 336, 624}, '{272, 1920, 1125, 1, 41, 558, 564, 603, 1121},
      '{376, 1920, 1250, 1, 45, 621, 626, 670, 1246}};
   localparam vpc_fmt_t SMALL = '{8, 8, 8, 1, 2, 4, 5, 6, 8};
   localparam int FRAME = 8 * (SMALL[0] + SMALL[1]) * SMALL[2];
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic vid_clk;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, frame_irq;
   logic [1:0] bresp, rresp, dbg_suspend, tx_fetch_start, tx_fetch_repeat;
   logic [1:0] rx_valid, tx_pix_active, tx_underflow;
   logic [7:0] rx_pin [NUM_RX];
   logic [7:0] rx_data [NUM_RX];
   logic [7:0] tx_fetch_data [2];
   logic [7:0] tx_pin [2];
   int errors = 0;
   int checks = 0;
   int cyc, n_irq0, n_irq2, n_rxv, n_pix, n_und;
   always #20 aclk = ~aclk;
   vpc_top #(.HIGH_RATE_GRADE(1'b0)) DUT (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
      .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
      .rready, .rdata, .rresp, .vid_clk, .dbg_suspend, .rx_pin, .rx_data, .rx_valid,
      .tx_fetch_data, .tx_fetch_start, .tx_fetch_repeat, .tx_pin, .tx_pix_active,
      .tx_underflow, .frame_irq);
   vpc_video_source #(.BLANK(8), .ACTIVE(8)) src (.vid_clk, .rx_pin);
   function automatic logic [31:0] word(input vpc_fmt_t p, input int w);
      case (w)
         0: return {3'h0, 13'(p[1]), 3'h0, 13'(p[0])};
         1: return 32'(p[2]);
         2: return {4'h0, 12'(p[4]), 4'h0, 12'(p[3])};
         3: return {4'h0, 12'(p[6]), 4'h0, 12'(p[5])};
         default: return {4'h0, 12'(p[8]), 4'h0, 12'(p[7])};
      endcase
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h got %h", n, e, g);
      end
   endtask
   // Both channels offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      fork
         begin
            do @(posedge aclk); while (awready !== 1'b1);
            awvalid <= 1'b0;
         end
         begin
            do @(posedge aclk); while (wready !== 1'b1);
            wvalid <= 1'b0;
         end
      join
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", 32'(er), 32'(bresp));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk("rdata", e, rdata);
      chk("rresp", 32'(er), 32'(rresp));
   endtask
   // Event counts over n cycles
   task automatic watch(input int n);
      {n_irq0, n_irq2, n_rxv, n_pix, n_und} = '0;
      repeat (n) begin
         @(posedge aclk);
         n_irq0 += frame_irq[0] === 1'b1;
         n_irq2 += frame_irq[2] === 1'b1;
         n_rxv += rx_valid[0] === 1'b1;
         n_pix += tx_pix_active[0] === 1'b1;
         n_und += tx_underflow[0] === 1'b1;
      end
   endtask
   task automatic wait_irq(input int ch);
      cyc = 0;
      do begin
         @(posedge aclk);
         cyc++;
      end while (frame_irq[ch] !== 1'b1 && cyc < 3000);
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Hang guard; the tests need about 15000 cycles
   initial begin
      repeat (40000) @(posedge aclk);
      errors++;
      conclude;
   end
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
      {wstrb, dbg_suspend} = {4'hf, 2'h0};
      tx_fetch_data = '{8'h5a, 8'ha5};
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("ready", 32'h3, {30'h0, awready, arready});
      rd(8'h00, 32'h0, RESP_OKAY);
      for (int w = 0; w < 5; w++) rd(8'(4 + 4 * w), word(FMT[0], w), RESP_OKAY);
      rd(8'h1c, 32'h0, RESP_SLVERR);
      wr(8'h18, 32'h1, RESP_SLVERR);
      wr(8'h02, 32'h1, RESP_SLVERR);
      $display("test reset done");
      for (int f = 0; f < 4; f++) begin
         for (int w = 0; w < 5; w++) begin
            wr(8'(8'h24 + 4 * w), word(FMT[f], w), RESP_OKAY);
            rd(8'(8'h24 + 4 * w), word(FMT[f], w), RESP_OKAY);
         end
      end
      wr(8'h20, 32'h8, RESP_OKAY);
      rd(8'h20, 32'h0, RESP_OKAY);
      $display("test formats done");
      for (int w = 0; w < 5; w++) wr(8'(4 + 4 * w), word(SMALL, w), RESP_OKAY);
      for (int w = 0; w < 5; w++) wr(8'(8'h44 + 4 * w), word(SMALL, w), RESP_OKAY);
      wr(OFF_GLOBAL, 32'h0, RESP_OKAY);
      wr(8'h00, 32'h1, RESP_OKAY);
      wr(8'h40, 32'h1, RESP_OKAY);
      wait_irq(0);
      wait_irq(0);
      chk("rx frame", 32'(FRAME), 32'(cyc));
      wait_irq(2);
      wait_irq(2);
      chk("tx frame", 32'(FRAME), 32'(cyc));
      watch(FRAME + 50);
      chk("rx bytes", 32'h1, 32'(n_rxv > 0));
      chk("pix off", 32'h0, 32'(n_pix));
      $display("test run done");
      wr(8'h40, 32'h3, RESP_OKAY);
      watch(FRAME + 80);
      chk("underflow", 32'h1, 32'(n_und > 0));
      chk("pix on", 32'h1, 32'(n_pix > 0));
      chk("underflow end", 32'h0, 32'(tx_underflow[0]));
      $display("test pixel done");
      wait_irq(2);
      dbg_suspend <= 2'b01;
      wr(8'h08, 32'ha, RESP_OKAY);
      watch(500);
      chk("frame finish", 32'h1, 32'(n_rxv > 0));
      watch(2400);
      chk("halt events", 32'h0, 32'(n_irq0 + n_irq2));
      chk("repeat", 32'h1, 32'(tx_fetch_repeat[0]));
      dbg_suspend <= 2'b00;
      wait_irq(2);
      chk("resume", 32'h1, 32'(cyc < 1300));
      chk("repeat off", 32'h0, 32'(tx_fetch_repeat[0]));
      repeat (3) wait_irq(0);
      chk("new lines", 32'(FRAME / 8 * 10), 32'(cyc));
      $display("test suspend done");
      wr(8'h00, 32'h0, RESP_OKAY);
      wr(8'h40, 32'h0, RESP_OKAY);
      watch(2100);
      chk("stopped", 32'h0, 32'(n_irq0 + n_irq2 + n_rxv + n_pix));
      $display("test shutdown done");
      conclude;
   end
endmodule
